/* File: common/mbrs_pkg.sv */
// Constants shared by the Modbus RTU read handler, its byte FIFO and its CRC stage.
// Assumes a single 50 MHz system clock and a byte-wide receiver on the same clock.
package mbrs_pkg;

   localparam int CLK_HZ = 50_000_000;
   localparam int BAUD = 19200;
   localparam int BITS_PER_CHAR = 11;
   // The frame gap is 3.5 character times, held as seven half characters.
   localparam int GAP_HALF_CHARS = 7;
   localparam longint GAP_NUM = longint'(GAP_HALF_CHARS) * longint'(BITS_PER_CHAR) * longint'(CLK_HZ);
   localparam longint GAP_DEN = 2 * longint'(BAUD);
   localparam int GAP_CYCLES = int'((GAP_NUM + GAP_DEN - 1) / GAP_DEN);

   localparam logic [7:0] FN_READ_HOLD = 8'h03;
   localparam logic [7:0] FN_PRESET_ONE = 8'h06;
   localparam logic [7:0] FN_DIAG = 8'h08;
   localparam logic [7:0] FN_PRESET_MULTI = 8'h10;
   localparam logic [7:0] FN_ACCESS_LOG = 8'h46;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
   localparam logic [7:0] EXC_ILLEGAL_DATA = 8'h03;
   localparam logic [7:0] BCAST_ADDR = 8'h00;

   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [15:0] CRC_RESIDUE = 16'h0000;

   localparam logic [3:0] MIN_FRAME_LEN = 4'h4;
   localparam logic [3:0] READ_QUERY_LEN = 4'h8;
   localparam logic [3:0] LEN_SAT = 4'hF;
   localparam logic [15:0] MAX_POINTS = 16'h007D;
   localparam logic [7:0] MIN_BYTE_COUNT = 8'h02;
   localparam logic [7:0] MAX_BYTE_COUNT = 8'h14;
   localparam int FIFO_DEPTH = 8;

   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_FUNC, S_BC, S_FETCH, S_HI, S_LO, S_CRCL, S_CRCH
   } mbrs_state_t;

endpackage

/* File: src/mbrs_crc.sv */
// One byte step of the CRC-16 used on the serial link, purely combinational.
// Assumes the caller holds the running value in its own register.
module mbrs_crc
   import mbrs_pkg::*;
(
   input wire logic [15:0] i_crc,
   input wire logic [7:0] i_byte,
   output logic [15:0] o_crc
);

   always_comb begin
      o_crc = i_crc ^ {8'h00, i_byte};
      for (int k = 0; k < 8; k++) begin
         o_crc = o_crc[0] ? ((o_crc >> 1) ^ CRC_POLY) : (o_crc >> 1);
      end
   end

endmodule

/* File: src/mbrs_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock; read data come straight from the storage flip-flops.
module mbrs_fifo
   import mbrs_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } mbrs_fifo_t;

   mbrs_fifo_t r;
   mbrs_fifo_t next_r;
   logic full;
   logic empty;

   assign empty = (r.wp == r.rp);
   assign full = (r.wp[AW-1:0] == r.rp[AW-1:0]) && (r.wp[AW] != r.rp[AW]);
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = r.mem[r.rp[AW-1:0]];

   always_comb begin
      next_r = r;
      if (i_in_valid && !full) begin
         next_r.mem[r.wp[AW-1:0]] = i_in_data;
         next_r.wp = r.wp + 1'b1;
      end
      if (i_out_ready && !empty) begin
         next_r.rp = r.rp + 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

endmodule

/* File: src/mbrs_handler.sv */
// Modbus RTU slave message handler: frames received bytes, checks them and answers holding register reads.
// Assumes a byte receiver and a byte transmitter on the same clock and a register map answering reads.
//
// How it works
// - preset-multiple accepted addressed and broadcast.
// - access-log handed out, never when broadcast.
// - CRC appended low byte then high.
// - recomputed CRC mismatch marks frame erroneous.
// - start address is register number minus 40001.
// - a read requests at most 125 registers; the handler answers at most 10, more get an illegal data exception.
// - broadcast holding register read is dropped.
// - response byte count stays within 2..20.
// - byte count is twice the requested points.
// - reply is address, function, count, data, CRC.
// - registers ascending, high byte before low.
// - reads reach every mapped holding register kind.
// - 3.5 character idle gap ends a frame.
// - hardware, framing or CRC errors get no reply.
// - broadcast presets executed, no broadcast query answered.
module mbrs_handler
   import mbrs_pkg::*;
#(
   parameter int GAP_LEN = GAP_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_station,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   input wire logic i_rx_err,
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   input wire logic i_tx_ready,
   output logic o_reg_rd_req,
   output logic [15:0] o_reg_rd_addr,
   input wire logic i_reg_rd_ack,
   input wire logic [15:0] i_reg_rd_data,
   output logic o_cmd_valid,
   output logic o_cmd_bcast,
   output logic [7:0] o_cmd_func,
   output logic [15:0] o_cmd_word0,
   output logic [15:0] o_cmd_word1,
   output logic o_crc_err,
   output logic o_busy
);

   localparam int GW = $clog2(GAP_LEN + 1);

   typedef struct packed {
      mbrs_state_t st;
      logic [GW-1:0] gap;
      logic in_frame;
      logic [3:0] len;
      logic [7:0] addr;
      logic [7:0] func;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [7:0] b4;
      logic [7:0] b5;
      logic [15:0] rcrc;
      logic bad;
      logic [15:0] tcrc;
      logic exc;
      logic [7:0] excode;
      logic [3:0] left;
      logic [15:0] raddr;
      logic [15:0] rdata;
      logic cmd_valid;
      logic cmd_bcast;
      logic crc_err;
   } mbrs_hdl_t;

   mbrs_hdl_t r;
   mbrs_hdl_t next_r;

   logic fend;
   logic frame_good;
   logic for_me;
   logic bcast;
   logic [15:0] points;
   logic read_ok;
   logic [15:0] rx_base;
   logic [15:0] rx_crc;
   logic [15:0] tx_crc;
   logic [7:0] tx_byte;
   logic push;
   logic fifo_ready;
   logic taken;

   ////////////////////////////////////////////////////////////////////////////
   // Frame checks.

   assign fend = r.in_frame && !i_rx_valid && (r.gap == GW'(GAP_LEN - 1));
   assign frame_good = !r.bad && (r.len >= MIN_FRAME_LEN) && (r.rcrc == CRC_RESIDUE);
   assign bcast = (r.addr == BCAST_ADDR);
   assign for_me = bcast || (r.addr == i_station);
   assign points = {r.b4, r.b5};
   assign read_ok = (points != 16'h0000) && (points <= MAX_POINTS)
                    && ({1'b0, points[6:0]} <= MAX_BYTE_COUNT[7:0] >> 1) && (points[15:7] == 9'h000)
                    && (r.len == READ_QUERY_LEN);
   assign rx_base = r.in_frame ? r.rcrc : CRC_INIT;

   mbrs_crc u_rx_crc (
      .i_crc(rx_base),
      .i_byte(i_rx_data),
      .o_crc(rx_crc)
   );

   mbrs_crc u_tx_crc (
      .i_crc(r.tcrc),
      .i_byte(tx_byte),
      .o_crc(tx_crc)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Transmit byte selection.

   always_comb begin
      push = 1'b1;
      case (r.st)
         S_ADDR: tx_byte = r.addr;
         S_FUNC: tx_byte = r.exc ? (r.func | EXC_FLAG) : r.func;
         S_BC: tx_byte = r.exc ? r.excode : {3'h0, r.left, 1'b0};
         S_HI: tx_byte = r.rdata[15:8];
         S_LO: tx_byte = r.rdata[7:0];
         S_CRCL: tx_byte = r.tcrc[7:0];
         S_CRCH: tx_byte = r.tcrc[15:8];
         default: begin
            tx_byte = 8'h00;
            push = 1'b0;
         end
      endcase
   end

   assign taken = push && fifo_ready;

   mbrs_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_in_valid(push),
      .i_in_data(tx_byte),
      .o_in_ready(fifo_ready),
      .o_out_valid(o_tx_valid),
      .o_out_data(o_tx_data),
      .i_out_ready(i_tx_ready)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      next_r = r;
      next_r.cmd_valid = 1'b0;
      next_r.crc_err = 1'b0;
      // Bytes arriving while a reply is in progress spoil the frame, since the header is still in use.
      if (i_rx_valid) begin
         next_r.in_frame = 1'b1;
         next_r.gap = '0;
         next_r.rcrc = rx_crc;
         next_r.len = !r.in_frame ? 4'h1 : ((r.len == LEN_SAT) ? LEN_SAT : r.len + 4'h1);
         next_r.bad = (r.in_frame && r.bad) || i_rx_err || (r.st != S_IDLE);
         if (r.st == S_IDLE) begin
            case (r.in_frame ? r.len : 4'h0)
               4'h0: next_r.addr = i_rx_data;
               4'h1: next_r.func = i_rx_data;
               4'h2: next_r.b2 = i_rx_data;
               4'h3: next_r.b3 = i_rx_data;
               4'h4: next_r.b4 = i_rx_data;
               4'h5: next_r.b5 = i_rx_data;
               default: next_r.b5 = r.b5;
            endcase
         end
      end else if (r.in_frame) begin
         next_r.bad = r.bad || i_rx_err;
         if (fend) begin
            next_r.in_frame = 1'b0;
         end else begin
            next_r.gap = r.gap + 1'b1;
         end
      end
      if (fend && r.st == S_IDLE) begin
         if (!frame_good) begin
            next_r.crc_err = !r.bad && (r.len >= MIN_FRAME_LEN);
         end else if (for_me) begin
            next_r.tcrc = CRC_INIT;
            next_r.exc = 1'b0;
            case (r.func)
               FN_READ_HOLD: begin
                  if (!bcast) begin
                     next_r.st = S_ADDR;
                     next_r.exc = !read_ok;
                     next_r.excode = EXC_ILLEGAL_DATA;
                     next_r.left = points[3:0];
                     next_r.raddr = {r.b2, r.b3};
                  end
               end
               FN_PRESET_MULTI, FN_PRESET_ONE: begin
                  next_r.cmd_valid = 1'b1;
                  next_r.cmd_bcast = bcast;
               end
               FN_ACCESS_LOG, FN_DIAG: begin
                  next_r.cmd_valid = !bcast;
                  next_r.cmd_bcast = 1'b0;
               end
               default: begin
                  if (!bcast) begin
                     next_r.st = S_ADDR;
                     next_r.exc = 1'b1;
                     next_r.excode = EXC_ILLEGAL_FUNC;
                  end
               end
            endcase
         end
      end
      if (taken && r.st != S_CRCL && r.st != S_CRCH) begin
         next_r.tcrc = tx_crc;
      end
      case (r.st)
         S_ADDR: if (taken) next_r.st = S_FUNC;
         S_FUNC: if (taken) next_r.st = S_BC;
         S_BC: if (taken) next_r.st = r.exc ? S_CRCL : S_FETCH;
         S_FETCH: begin
            if (i_reg_rd_ack) begin
               next_r.rdata = i_reg_rd_data;
               next_r.raddr = r.raddr + 16'h0001;
               next_r.left = r.left - 4'h1;
               next_r.st = S_HI;
            end
         end
         S_HI: if (taken) next_r.st = S_LO;
         S_LO: if (taken) next_r.st = (r.left == 4'h0) ? S_CRCL : S_FETCH;
         S_CRCL: if (taken) next_r.st = S_CRCH;
         S_CRCH: if (taken) next_r.st = S_IDLE;
         default: begin
            // Idle keeps whatever the frame-end decode above chose, so a reply can start.
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign o_reg_rd_req = (r.st == S_FETCH);
   assign o_reg_rd_addr = r.raddr;
   assign o_cmd_valid = r.cmd_valid;
   assign o_cmd_bcast = r.cmd_bcast;
   assign o_cmd_func = r.func;
   assign o_cmd_word0 = {r.b2, r.b3};
   assign o_cmd_word1 = {r.b4, r.b5};
   assign o_crc_err = r.crc_err;
   assign o_busy = (r.st != S_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   a_bad_crc_quiet: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (fend && r.st == S_IDLE && r.rcrc != CRC_RESIDUE) |=> (r.st == S_IDLE) [*2])
      else $error("reply started for a frame with a bad CRC");
   a_err_frame_quiet: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (fend && r.st == S_IDLE && r.bad) |=> (r.st == S_IDLE && !r.cmd_valid))
      else $error("errored frame was acted on");
   a_bcast_silent: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (fend && r.st == S_IDLE && r.addr == BCAST_ADDR) |=> (r.st == S_IDLE))
      else $error("broadcast query got a reply");
   a_bcast_preset: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (fend && r.st == S_IDLE && frame_good && bcast && r.func == FN_PRESET_MULTI) |=> (r.cmd_valid && r.cmd_bcast))
      else $error("broadcast preset multiple not executed");
   a_log_no_bcast: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (fend && r.st == S_IDLE && bcast && r.func == FN_ACCESS_LOG) |=> !r.cmd_valid)
      else $error("broadcast access log executed");
   a_count_range: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (r.st == S_BC && !r.exc) |-> (tx_byte >= MIN_BYTE_COUNT && tx_byte <= MAX_BYTE_COUNT))
      else $error("byte count out of range");
   a_count_twice: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (fend && r.st == S_IDLE && frame_good && for_me && !bcast && r.func == FN_READ_HOLD && read_ok)
      |=> (r.left == $past(points[3:0])) ##[1:1000] (r.st == S_BC && tx_byte == {$past(r.b5[6:0], 2), 1'b0}))
      else $error("byte count is not twice the points");
   a_reg_step: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (r.st == S_FETCH && i_reg_rd_ack) |=> (r.raddr == $past(r.raddr) + 16'h0001 && r.st == S_HI
      && r.rdata == $past(i_reg_rd_data)))
      else $error("register order or data wrong");
   a_crc_order: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (r.st == S_CRCL && taken) |=> (r.st == S_CRCH && tx_byte == $past(r.tcrc[15:8])))
      else $error("CRC high byte not after low byte");
   a_exc_flag: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (r.st == S_FUNC && r.exc) |-> (tx_byte[7] && tx_byte[6:0] == r.func[6:0]))
      else $error("exception reply lacks the flag");
   a_gap_restart: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      i_rx_valid |=> (r.in_frame && r.gap == '0))
      else $error("byte did not restart the gap timer");

endmodule

/* File: tb/mbrs_tb_regmap.sv */
// Behavioural holding register map that answers the handler's read requests.
// Assumes one request at a time, held until the acknowledge pulse is seen.
module mbrs_tb_regmap (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_slow,
   input wire logic i_req,
   input wire logic [15:0] i_addr,
   output logic o_ack,
   output logic [15:0] o_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_cnt;

   ////////////////////////////////////////////////////////////////////////////////
   // register address lookup.
   // Data outside the acknowledge cycle toggles every cycle, so a sample one cycle late reads inverted but one two cycles late matches again.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ack <= 1'b0;
         o_data <= 16'h0000;
         wait_cnt <= 2'h0;
      end else if (i_req && !o_ack && (!i_slow || wait_cnt == 2'h3)) begin
         o_ack <= 1'b1;
         o_data <= i_addr ^ 16'hC3A5;
         wait_cnt <= 2'h0;
      end else begin
         o_ack <= 1'b0;
         o_data <= ~o_data;
         wait_cnt <= (i_req && !o_ack) ? wait_cnt + 2'h1 : 2'h0;
      end
   end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the read handler: frames go in as byte pulses, replies are gathered.
// Assumes a shortened frame gap and a register map model on the far side.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import mbrs_pkg::*;
   localparam int GAP = 20;
   logic i_ref_clk, i_rst, rx_valid, rx_err, tx_ready, stall, slow, tx_valid, req, ack;
   logic cmd_valid, cmd_bcast, crc_err, busy, rdy;
   logic [7:0] rx_data, tx_data, cmd_func;
   logic [15:0] rd_addr, rd_data, cmd_w0, cmd_w1;
   int bad_count, checks, cyc, n_cmd, n_crc;
   logic [7:0] fr[$], got[$], exp_q[$];
   logic [7:0] last_func;
   logic last_bcast;
   logic [15:0] last_w0, last_w1;

   mbrs_handler #(.GAP_LEN(GAP)) u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_station(8'h11),
      .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_rx_err(rx_err), .o_tx_valid(tx_valid),
      .o_tx_data(tx_data), .i_tx_ready(tx_ready), .o_reg_rd_req(req), .o_reg_rd_addr(rd_addr),
      .i_reg_rd_ack(ack), .i_reg_rd_data(rd_data), .o_cmd_valid(cmd_valid), .o_cmd_bcast(cmd_bcast),
      .o_cmd_func(cmd_func), .o_cmd_word0(cmd_w0), .o_cmd_word1(cmd_w1), .o_crc_err(crc_err), .o_busy(busy));
   mbrs_tb_regmap u_map (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_slow(slow), .i_req(req),
      .i_addr(rd_addr), .o_ack(ack), .o_data(rd_data));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_ref_clk = 1'b0;
      forever #10 i_ref_clk = ~i_ref_clk;
   end

   // The transmitter stalls two cycles in three when asked, to fill the reply FIFO.
   // Outputs are gathered at the falling edge, where they stand settled for the next rising edge.
   always @(negedge i_ref_clk) begin
      cyc++;
      rdy = !stall || (cyc % 3 == 0);
      tx_ready <= rdy;
      if (tx_valid && rdy) got.push_back(tx_data);
      if (crc_err) n_crc++;
      if (cmd_valid) begin
         n_cmd++;
         last_func = cmd_func;
         last_bcast = cmd_bcast;
         last_w0 = cmd_w0;
         last_w1 = cmd_w1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic add_crc(ref logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
   endtask

   task automatic read_query(logic [7:0] addr, logic [15:0] st, logic [7:0] n);
      fr = '{addr, 8'h03, st[15:8], st[7:0], 8'h00, n};
      add_crc(fr);
   endtask

   task automatic send_frame(bit spoil);
      got.delete();
      n_cmd = 0;
      n_crc = 0;
      foreach (fr[i]) begin
         @(negedge i_ref_clk);
         rx_valid = 1'b1;
         rx_data = fr[i];
         rx_err = spoil && i == 3;
         @(negedge i_ref_clk);
         rx_valid = 1'b0;
         rx_err = 1'b0;
      end
      repeat (GAP + 4) @(negedge i_ref_clk);
      for (int k = 0; k < 800 && (busy !== 1'b0 || tx_valid !== 1'b0); k++) @(negedge i_ref_clk);
      check("idle", {14'h0, busy, tx_valid}, 16'h0000);
      check("reply_len", 16'(got.size()), 16'(exp_q.size()));
      foreach (exp_q[i]) if (i < got.size()) check("reply_byte", {8'h00, got[i]}, {8'h00, exp_q[i]});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_read_ok();
      logic [15:0] st[3] = '{16'h03EB, 16'h0000, 16'h0100};
      int n[3] = '{3, 1, 10};
      logic [15:0] d;
      for (int t = 0; t < 3; t++) begin
         slow = (t != 1);
         stall = (t != 1);
         read_query(8'h11, st[t], 8'(n[t]));
         if (t == 0) check("query_crc", {fr[6], fr[7]}, 16'h772B);
         exp_q = '{8'h11, 8'h03, 8'(2 * n[t])};
         for (int i = 0; i < n[t]; i++) begin
            d = (st[t] + 16'(i)) ^ 16'hC3A5;
            exp_q.push_back(d[15:8]);
            exp_q.push_back(d[7:0]);
         end
         add_crc(exp_q);
         send_frame(1'b0);
      end
      $display("test read_ok finished");
   endtask

   task automatic t_exceptions();
      int n[2] = '{0, 11};
      for (int t = 0; t < 2; t++) begin
         read_query(8'h11, 16'h0004, 8'(n[t]));
         exp_q = '{8'h11, 8'h83, EXC_ILLEGAL_DATA};
         add_crc(exp_q);
         send_frame(1'b0);
      end
      fr = '{8'h11, 8'h41, 8'h00, 8'h00, 8'h00, 8'h01};
      add_crc(fr);
      exp_q = '{8'h11, 8'hC1, EXC_ILLEGAL_FUNC};
      add_crc(exp_q);
      send_frame(1'b0);
      $display("test exceptions finished");
   endtask

   task automatic t_dropped();
      exp_q.delete();
      read_query(8'h11, 16'h0002, 8'h02);
      fr[7] = fr[7] ^ 8'h01;
      send_frame(1'b0);
      check("crc_err_count", 16'(n_crc), 16'h0001);
      read_query(8'h11, 16'h0002, 8'h02);
      send_frame(1'b1);
      check("spoiled_crc_err", 16'(n_crc), 16'h0000);
      read_query(8'h12, 16'h0002, 8'h02);
      send_frame(1'b0);
      read_query(BCAST_ADDR, 16'h0002, 8'h02);
      send_frame(1'b0);
      check("bcast_read_cmd", 16'(n_cmd), 16'h0000);
      $display("test dropped finished");
   endtask

   task automatic t_commands();
      exp_q.delete();
      fr = '{BCAST_ADDR, FN_PRESET_MULTI, 8'h00, 8'h05, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34};
      add_crc(fr);
      send_frame(1'b0);
      check("multi_cmd", 16'(n_cmd), 16'h0001);
      check("multi_func", {8'h00, last_func}, 16'h0010);
      check("multi_bcast", {15'h0, last_bcast}, 16'h0001);
      check("multi_start", last_w0, 16'h0005);
      check("multi_count", last_w1, 16'h0001);
      fr = '{8'h11, FN_ACCESS_LOG, 8'h00, 8'h00, 8'h00, 8'h00};
      add_crc(fr);
      send_frame(1'b0);
      check("log_cmd", 16'(n_cmd), 16'h0001);
      check("log_func", {8'h00, last_func}, 16'h0046);
      check("log_bcast", {15'h0, last_bcast}, 16'h0000);
      fr[0] = BCAST_ADDR;
      void'(fr.pop_back());
      void'(fr.pop_back());
      add_crc(fr);
      send_frame(1'b0);
      check("log_bcast_cmd", 16'(n_cmd), 16'h0000);
      fr = '{BCAST_ADDR, FN_PRESET_ONE, 8'h00, 8'h0D, 8'h17, 8'h70};
      add_crc(fr);
      send_frame(1'b0);
      check("single_cmd", 16'(n_cmd), 16'h0001);
      check("single_func", {8'h00, last_func}, 16'h0006);
      check("single_bcast", {15'h0, last_bcast}, 16'h0001);
      check("single_data", last_w1, 16'h1770);
      fr = '{8'h11, FN_DIAG, 8'h00, 8'h00, 8'h12, 8'h34};
      add_crc(fr);
      send_frame(1'b0);
      check("diag_cmd", 16'(n_cmd), 16'h0001);
      check("diag_func", {8'h00, last_func}, 16'h0008);
      check("diag_data", last_w1, 16'h1234);
      $display("test commands finished");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      i_rst = 1'b1;
      rx_valid = 1'b0;
      rx_err = 1'b0;
      rx_data = 8'h00;
      stall = 1'b0;
      slow = 1'b0;
      repeat (12) @(negedge i_ref_clk);
      i_rst = 1'b0;
      t_read_ok();
      t_exceptions();
      t_dropped();
      t_commands();
      print_verdict();
   end

   // Roughly fifteen frames of under two hundred cycles each; the margin is generous.
   initial begin
      #(20 * 40000);
      bad_count++;
      print_verdict();
   end
endmodule
